// *** rtl/rttx_top.sv ***
// Receive teardown command and transmit interrupt status register bank on AHB-Lite.
`timescale 1ns/1ns
`include "rttx_regs.svh"

// Overview of operation
// - Writing code 0-7 to teardown bits 2-0 tears down exactly that receive channel.
// - The teardown register always reads as zero.
// - Unmasked status bit n shows transmit channel n pending, ignoring the enables.
// - Masked status bit n shows channel n pending only while its enable is set.
// - Both status registers are read-only, zero after reset, bits 31-8 read zero.
// - Writing one to an enable-set bit enables that channel; zero changes nothing.
// - Writing one to an enable-clear bit disables that channel; zero changes nothing.
module rttx_top (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [7:0] TX_PEND,
    output rttx_pkg::rttx_td_type RX_TEARDOWN,
    output logic [7:0] RX_TEARDOWN_SEL,
    output logic TX_IRQ,
    output logic EVT_IRQ
);

    // Word-aligned address match, shared by every strobe and the read mux.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction

    function automatic logic [7:0] chan_onehot(input logic [2:0] code);
        chan_onehot = 8'h01 << code;
    endfunction

    rttx_pkg::rttx_req_type req;
    logic [31:0] rd_data;
    logic [7:0] raw_reg;
    logic [7:0] en_reg;
    logic [7:0] masked_w;
    logic [7:0] pend_rise;
    logic [8:0] evt_reg;
    logic [8:0] evt_set;
    logic [8:0] evt_mask_reg;
    logic evt_rd;
    logic td_wr;
    rttx_pkg::rttx_td_type td_reg;
    logic [7:0] td_sel_reg;
    logic tx_irq_reg;
    logic evt_irq_reg;

    rttx_ahb_slave u_slave (
        .clk(CLK),
        .reset_n(RESET_N),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hsize(HSIZE),
        .hwdata(HWDATA),
        .hready(HREADY),
        .rd_data(rd_data),
        .req(req),
        .hrdata(HRDATA),
        .hreadyout(HREADYOUT),
        .hresp(HRESP)
    );

    assign td_wr = req.wr && hit(req.addr, `RTTX_OFF_TEARDOWN);
    assign evt_rd = req.rd && hit(req.addr, `RTTX_OFF_EVT_STAT);
    assign masked_w = raw_reg & en_reg;

    // The channel lines are taken as synchronous, so one flop stage is enough.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            raw_reg <= `RTTX_PEND_RST;
        else
            raw_reg <= TX_PEND;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            en_reg <= `RTTX_EN_RST;
        else if (req.wr && hit(req.addr, `RTTX_OFF_EN_SET))
            en_reg <= en_reg | req.wdata[7:0];
        else if (req.wr && hit(req.addr, `RTTX_OFF_EN_CLEAR))
            en_reg <= en_reg & ~req.wdata[7:0];
    end

    // The code is not stored for reading; valid and select pulse for one cycle, the channel field holds until the next teardown write.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            td_reg.valid <= 1'b0;
            td_reg.chan <= 3'h0;
            td_sel_reg <= 8'h00;
        end
        else if (td_wr)
        begin
            td_reg.valid <= 1'b1;
            td_reg.chan <= req.wdata[`RTTX_TD_CHAN_MSB:`RTTX_TD_CHAN_LSB];
            td_sel_reg <= chan_onehot(req.wdata[`RTTX_TD_CHAN_MSB:`RTTX_TD_CHAN_LSB]);
        end
        else
        begin
            td_reg.valid <= 1'b0;
            td_sel_reg <= 8'h00;
        end
    end

    assign pend_rise = TX_PEND & ~raw_reg;
    assign evt_set = {td_wr, pend_rise};

    // A new event in the same cycle as the clearing read survives the read.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            evt_reg <= `RTTX_EVT_RST;
        else if (evt_rd)
            evt_reg <= evt_set;
        else
            evt_reg <= evt_reg | evt_set;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            evt_mask_reg <= `RTTX_EVT_RST;
        else if (req.wr && hit(req.addr, `RTTX_OFF_EVT_MASK))
            evt_mask_reg <= req.wdata[8:0];
    end

    // Both interrupt lines lag their cause by one cycle so they leave flip-flops.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            tx_irq_reg <= 1'b0;
            evt_irq_reg <= 1'b0;
        end
        else
        begin
            tx_irq_reg <= |masked_w;
            evt_irq_reg <= |(evt_reg & evt_mask_reg);
        end
    end

    // Unmapped offsets read as zero with an OKAY response.
    always_comb
    begin
        rd_data = `RTTX_ZERO_WORD;
        if (hit(req.addr, `RTTX_OFF_RAW))
            rd_data = {24'h000000, raw_reg};
        else if (hit(req.addr, `RTTX_OFF_MASKED))
            rd_data = {24'h000000, masked_w};
        else if (hit(req.addr, `RTTX_OFF_EN_SET) || hit(req.addr, `RTTX_OFF_EN_CLEAR))
            rd_data = {24'h000000, en_reg};
        else if (hit(req.addr, `RTTX_OFF_EVT_STAT))
            rd_data = {23'h000000, evt_reg};
        else if (hit(req.addr, `RTTX_OFF_EVT_MASK))
            rd_data = {23'h000000, evt_mask_reg};
    end

    assign RX_TEARDOWN = td_reg;
    assign RX_TEARDOWN_SEL = td_sel_reg;
    assign TX_IRQ = tx_irq_reg;
    assign EVT_IRQ = evt_irq_reg;

    property p_td_cmd;
        @(posedge CLK) disable iff (!RESET_N)
        td_wr |=> RX_TEARDOWN.valid && RX_TEARDOWN.chan == $past(req.wdata[2:0])
            && RX_TEARDOWN_SEL == (8'h01 << $past(req.wdata[2:0]));
    endproperty
    a_td_cmd: assert property (p_td_cmd) else $error("teardown command lost or wrong channel");

    property p_td_only;
        @(posedge CLK) disable iff (!RESET_N)
        !td_wr |=> !RX_TEARDOWN.valid && RX_TEARDOWN_SEL == 8'h00;
    endproperty
    a_td_only: assert property (p_td_only) else $error("teardown issued without a write");

    property p_td_reads_zero;
        @(posedge CLK) disable iff (!RESET_N)
        req.rd && hit(req.addr, `RTTX_OFF_TEARDOWN) |=> HRDATA == 32'h00000000;
    endproperty
    a_td_reads_zero: assert property (p_td_reads_zero) else $error("teardown register read not zero");

    property p_raw_read;
        @(posedge CLK) disable iff (!RESET_N)
        req.rd && hit(req.addr, `RTTX_OFF_RAW) |=> HREADYOUT && HRDATA[7:0] == $past(raw_reg);
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("unmasked status read wrong");

    // Gated on the sampled reset so the reset edge itself, with channels already pending, is not checked.
    property p_raw_follows;
        @(posedge CLK) disable iff (!RESET_N)
        RESET_N |=> raw_reg == $past(TX_PEND);
    endproperty
    a_raw_follows: assert property (p_raw_follows) else $error("unmasked status does not follow channels");

    property p_masked_read;
        @(posedge CLK) disable iff (!RESET_N)
        req.rd && hit(req.addr, `RTTX_OFF_MASKED) |=> HRDATA[7:0] == ($past(raw_reg) & $past(en_reg));
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("masked status read wrong");

    property p_high_zero;
        @(posedge CLK) disable iff (!RESET_N)
        req.rd && (hit(req.addr, `RTTX_OFF_RAW) || hit(req.addr, `RTTX_OFF_MASKED)) |=> HRDATA[31:8] == 24'h000000;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("status bits 31-8 not zero");

    property p_reset_zero;
        @(posedge CLK)
        !RESET_N |=> raw_reg == 8'h00 && en_reg == 8'h00 && !TX_IRQ;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");

    property p_en_set;
        @(posedge CLK) disable iff (!RESET_N)
        req.wr && hit(req.addr, `RTTX_OFF_EN_SET) |=>
            (en_reg & $past(req.wdata[7:0])) == $past(req.wdata[7:0]) && ($past(en_reg) & ~en_reg) == 8'h00;
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable set write misbehaved");

    property p_en_clear;
        @(posedge CLK) disable iff (!RESET_N)
        req.wr && hit(req.addr, `RTTX_OFF_EN_CLEAR) |=>
            (en_reg & $past(req.wdata[7:0])) == 8'h00 && (en_reg & ~$past(en_reg)) == 8'h00;
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("enable clear write misbehaved");

    property p_tx_irq;
        @(posedge CLK) disable iff (!RESET_N)
        ##1 TX_IRQ == (|$past(masked_w));
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt disagrees with masked status");

    property p_evt_sticky;
        @(posedge CLK) disable iff (!RESET_N)
        evt_reg[`RTTX_EVT_TD_BIT] && !evt_rd |=> evt_reg[`RTTX_EVT_TD_BIT];
    endproperty
    a_evt_sticky: assert property (p_evt_sticky) else $error("sticky event lost without a read");

    property p_td_sel_onehot;
        @(posedge CLK) disable iff (!RESET_N)
        RX_TEARDOWN.valid |-> $onehot(RX_TEARDOWN_SEL) && RX_TEARDOWN_SEL[RX_TEARDOWN.chan];
    endproperty
    a_td_sel_onehot: assert property (p_td_sel_onehot) else $error("teardown select wrong");

    property p_td_chan_hold;
        @(posedge CLK) disable iff (!RESET_N)
        !td_wr |=> $stable(RX_TEARDOWN.chan);
    endproperty
    a_td_chan_hold: assert property (p_td_chan_hold) else $error("teardown channel moved without a write");

    property p_en_hold;
        @(posedge CLK) disable iff (!RESET_N)
        !(req.wr && (hit(req.addr, `RTTX_OFF_EN_SET) || hit(req.addr, `RTTX_OFF_EN_CLEAR))) |=>
            $stable(en_reg);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enables changed without an enable write");

    property p_en_read;
        @(posedge CLK) disable iff (!RESET_N)
        req.rd && (hit(req.addr, `RTTX_OFF_EN_SET) || hit(req.addr, `RTTX_OFF_EN_CLEAR)) |=>
            HRDATA == {24'h000000, $past(en_reg)};
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable read back wrong");

    property p_hresp_okay;
        @(posedge CLK) disable iff (!RESET_N)
        !HRESP;
    endproperty
    a_hresp_okay: assert property (p_hresp_okay) else $error("bus response not OKAY");

    property p_evt_clear;
        @(posedge CLK) disable iff (!RESET_N)
        evt_rd |=> evt_reg == $past(evt_set);
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event read did not clear or lost a new event");

    property p_evt_irq;
        @(posedge CLK) disable iff (!RESET_N)
        RESET_N |=> EVT_IRQ == (|($past(evt_reg) & $past(evt_mask_reg)));
    endproperty
    a_evt_irq: assert property (p_evt_irq) else $error("event interrupt disagrees with masked events");

    property p_reset_out;
        @(posedge CLK)
        !RESET_N |=> HRDATA == 32'h00000000 && HREADYOUT && !HRESP && !RX_TEARDOWN.valid
            && RX_TEARDOWN_SEL == 8'h00 && !EVT_IRQ;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");

endmodule // rttx_top

// *** rtl/rttx_regs.svh ***
// Register offsets, field positions and reset values of the teardown and transmit interrupt slice.
`ifndef RTTX_REGS_SVH
`define RTTX_REGS_SVH

`define RTTX_NCHAN 8
`define RTTX_EVT_W 9
`define RTTX_ADDR_W 8

`define RTTX_OFF_TEARDOWN 8'h00
`define RTTX_OFF_RAW 8'h04
`define RTTX_OFF_MASKED 8'h08
`define RTTX_OFF_EN_SET 8'h0C
`define RTTX_OFF_EN_CLEAR 8'h10
`define RTTX_OFF_EVT_STAT 8'h14
`define RTTX_OFF_EVT_MASK 8'h18

`define RTTX_TD_CHAN_MSB 2
`define RTTX_TD_CHAN_LSB 0
`define RTTX_EVT_TD_BIT 8

`define RTTX_ZERO_WORD 32'h00000000
`define RTTX_PEND_RST 8'h00
`define RTTX_EN_RST 8'h00
`define RTTX_EVT_RST 9'h000
`define RTTX_HSIZE_WORD 3'h2

`endif

// *** rtl/rttx_pkg.sv ***
// Types shared by the bus front end and the register bank.
package rttx_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } rttx_req_type;

    typedef struct packed {
        logic valid;
        logic [2:0] chan;
    } rttx_td_type;

endpackage

// *** rtl/rttx_ahb_slave.sv ***
// AHB-Lite slave front end that turns bus transfers into one-cycle register strobes.
`timescale 1ns/1ns
`include "rttx_regs.svh"

module rttx_ahb_slave (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] rd_data,
    output rttx_pkg::rttx_req_type req,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    logic accept;
    logic pend_reg;
    logic wr_reg;
    logic word_reg;
    logic [7:0] addr_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic hresp_reg;

    assign accept = hsel && htrans[1] && hready;

    // One wait state lets the read data leave a flip-flop instead of the decoder.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pend_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
        else
        begin
            pend_reg <= accept;
            hreadyout_reg <= !accept;
            hresp_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wr_reg <= 1'b0;
            word_reg <= 1'b0;
            addr_reg <= 8'h00;
        end
        else if (accept)
        begin
            wr_reg <= hwrite;
            word_reg <= (hsize == `RTTX_HSIZE_WORD);
            addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            hrdata_reg <= `RTTX_ZERO_WORD;
        else if (pend_reg && !wr_reg)
            hrdata_reg <= rd_data;
    end

    // Writes narrower than a word are dropped, since every register is a whole word.
    assign req.wr = pend_reg && wr_reg && word_reg;
    assign req.rd = pend_reg && !wr_reg;
    assign req.addr = addr_reg;
    assign req.wdata = hwdata;
    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;

    property p_one_wait;
        @(posedge clk) disable iff (!reset_n)
        accept |=> !hreadyout ##1 hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("slave did not answer after one wait state");

endmodule // rttx_ahb_slave

// *** dv/rttx_tb.sv ***
// Self-checking testbench for the teardown and transmit interrupt register bank.
`timescale 1ns/1ns

module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] tx_pend = 8'h00;
    rttx_pkg::rttx_td_type td;
    logic [7:0] td_sel;
    logic tx_irq;
    logic evt_irq;
    int error_cnt = 0;
    int n_checks = 0;
    logic [11:0] td_cap;
    logic [31:0] rd;

    assign hready = hreadyout;

    rttx_top dut (
        .CLK(clk),
        .RESET_N(reset_n),
        .HSEL(hsel),
        .HADDR(haddr),
        .HTRANS(htrans),
        .HWRITE(hwrite),
        .HSIZE(hsize),
        .HWDATA(hwdata),
        .HREADY(hready),
        .HRDATA(hrdata),
        .HREADYOUT(hreadyout),
        .HRESP(hresp),
        .TX_PEND(tx_pend),
        .RX_TEARDOWN(td),
        .RX_TEARDOWN_SEL(td_sel),
        .TX_IRQ(tx_irq),
        .EVT_IRQ(evt_irq)
    );

    always #5 clk = ~clk;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Ready and data are looked at mid-cycle, so the decision never races the design's own edge updates.
    task automatic wait_rdy;
        logic r;
        do
        begin
            @(negedge clk);
            r = hready;
            rd = hrdata;
            td_cap = {td, td_sel};
            @(posedge clk);
        end
        while (r !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy;
        chk("hresp", 32'h00000000, {31'h00000000, hresp});
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(name, exp, rd);
    endtask

    task automatic lvl_chk(input logic tx, input logic evt);
        @(negedge clk);
        chk("irq_lines", {30'h00000000, tx, evt}, {30'h00000000, tx_irq, evt_irq});
        chk("teardown_idle", 32'h00000000, {31'h00000000, td.valid});
        @(posedge clk);
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        tally_and_finish;
    end

    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdchk("raw", 8'h04, 32'h00000000);
        rdchk("masked", 8'h08, 32'h00000000);
        rdchk("enables", 8'h0C, 32'h00000000);
        lvl_chk(1'b0, 1'b0);
        $display("test reset_values done");
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, 8'h00, 32'hFFFFFFF8 | c);
            chk("teardown", {20'h00000, 1'b1, c[2:0], 8'h01 << c}, {20'h00000, td_cap});
            lvl_chk(1'b0, 1'b0);
            rdchk("teardown_read", 8'h00, 32'h00000000);
        end
        $display("test teardown done");
        tx_pend <= 8'hA5;
        repeat (3) @(posedge clk);
        rdchk("raw", 8'h04, 32'h000000A5);
        rdchk("masked", 8'h08, 32'h00000000);
        bus(1'b1, 8'h0C, 32'hFFFFFF0F);
        bus(1'b1, 8'h0C, 32'h00000000);
        rdchk("enables", 8'h0C, 32'h0000000F);
        rdchk("masked", 8'h08, 32'h00000005);
        lvl_chk(1'b1, 1'b0);
        bus(1'b1, 8'h04, 32'hFFFFFFFF);
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        rdchk("raw", 8'h04, 32'h000000A5);
        rdchk("masked", 8'h08, 32'h00000005);
        bus(1'b1, 8'h10, 32'h00000005);
        bus(1'b1, 8'h10, 32'h00000000);
        rdchk("enables", 8'h10, 32'h0000000A);
        rdchk("masked", 8'h08, 32'h00000000);
        lvl_chk(1'b0, 1'b0);
        $display("test status_and_enables done");
        // The status holds every rising pending edge so far plus the teardown event.
        rdchk("evt_status", 8'h14, 32'h000001A5);
        rdchk("evt_status", 8'h14, 32'h00000000);
        bus(1'b1, 8'h18, 32'h000001FF);
        rdchk("evt_mask", 8'h18, 32'h000001FF);
        lvl_chk(1'b0, 1'b0);
        tx_pend <= 8'hA7;
        repeat (3) @(posedge clk);
        rdchk("masked", 8'h08, 32'h00000002);
        lvl_chk(1'b1, 1'b1);
        bus(1'b1, 8'h18, 32'h00000000);
        lvl_chk(1'b1, 1'b0);
        bus(1'b1, 8'h18, 32'h000001FF);
        lvl_chk(1'b1, 1'b1);
        rdchk("evt_status", 8'h14, 32'h00000002);
        lvl_chk(1'b1, 1'b0);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rdchk("unmapped", 8'h40, 32'h00000000);
        rdchk("enables", 8'h0C, 32'h0000000A);
        $display("test events done");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdchk("enables", 8'h0C, 32'h00000000);
        rdchk("masked", 8'h08, 32'h00000000);
        lvl_chk(1'b0, 1'b0);
        rdchk("raw", 8'h04, 32'h000000A7);
        $display("test second_reset done");
        tally_and_finish;
    end
endmodule // testbench
